// ---- core/pcm_regs.vh ----
// Constants for the PCM codec serial port: pin slots, codes and timing counts.
`ifndef PCM_REGS_VH
`define PCM_REGS_VH

// ----------------------------------------------------------------------------
// Pin slots in the synchroniser vector
// ----------------------------------------------------------------------------
`define PCM_PIN_MCLK    0
`define PCM_PIN_TFS     1
`define PCM_PIN_TBC     2
`define PCM_PIN_RFS     3
`define PCM_PIN_RBC     4
`define PCM_PIN_RDAT    5
`define PCM_PIN_PDN     6
`define PCM_PIN_LAW     7
`define PCM_PIN_COUNT   8

// ----------------------------------------------------------------------------
// Prescaler: master-clock edges per 8 kHz frame and the divide ratios
// ----------------------------------------------------------------------------
`define PCM_EDGES_1X    10'h028
`define PCM_EDGES_2X    10'h060
`define PCM_EDGES_6X    10'h0E0
`define PCM_EDGES_8X    10'h120
`define PCM_EDGES_10X   10'h190
`define PCM_RATIO_1     5'h01
`define PCM_RATIO_2     5'h02
`define PCM_RATIO_6     5'h06
`define PCM_RATIO_8     5'h08
`define PCM_RATIO_10    5'h0A
`define PCM_RATIO_16    5'h10

// ----------------------------------------------------------------------------
// Word codes (chord, step; sign added outside)
// ----------------------------------------------------------------------------
`define PCM_MU_FULL     7'h00
`define PCM_MU_ZERO     7'h7F
`define PCM_A_FULL      7'h2A
`define PCM_A_ZERO      7'h55
`define PCM_MU_TONE_A   7'h1E
`define PCM_MU_TONE_B   7'h0B
`define PCM_A_TONE_A    7'h34
`define PCM_A_TONE_B    7'h21

// ----------------------------------------------------------------------------
// Word source select and counts
// ----------------------------------------------------------------------------
`define PCM_SRC_USER    2'h0
`define PCM_SRC_ZERO    2'h1
`define PCM_SRC_TONE    2'h2
`define PCM_SRC_FULL    2'h3
`define PCM_BITS        4'h8
`define PCM_ARM_EDGES   2'h3
`define PCM_CLK_NS      10
`define PCM_PD_IDLE_NS  375000
`define PCM_PD_IDLE_CYC (`PCM_PD_IDLE_NS / `PCM_CLK_NS)
`define PCM_FIFO_DEPTH  16
`define PCM_FIFO_AW     4

`endif

// ---- core/pcm_word_fifo.v ----
// Word FIFO with a registered output stage for received PCM words.
`timescale 1ns/1ns

module pcm_word_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	input  wire             clk_sys,
	input  wire             rst_b,
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	output reg              out_valid,
	input  wire             out_ready,
	output reg  [WIDTH-1:0] out_data
);

	// ------------------------------------------------------------------------
	// Storage and pointers
	// ------------------------------------------------------------------------
	reg [WIDTH-1:0] mem_q [0:DEPTH-1]; // Word storage.
	reg [AW-1:0]    wr_q;              // Write pointer.
	reg [AW-1:0]    rd_q;              // Read pointer.
	reg [AW:0]      cnt_q;             // Words held in storage.
	wire            push;              // Accepted write this cycle.
	wire            pop;               // Storage word moves to the output stage.

	// Full is honest: the output stage counts apart, so ready falls at DEPTH.
	assign in_ready = (cnt_q != DEPTH[AW:0]);
	assign push     = in_valid && in_ready;
	assign pop      = (cnt_q != {(AW+1){1'b0}}) && (!out_valid || out_ready);

	// Storage write; no reset needed because the count guards every read.
	always @(posedge clk_sys) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	// Pointers, count and the output stage.
	always @(posedge clk_sys) begin
		if (!rst_b) begin
			wr_q      <= {AW{1'b0}};
			rd_q      <= {AW{1'b0}};
			cnt_q     <= {(AW+1){1'b0}};
			out_valid <= 1'b0;
			out_data  <= {WIDTH{1'b0}};
		end else begin
			if (push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (pop) begin
				rd_q      <= rd_q + 1'b1;
				out_data  <= mem_q[rd_q];
				out_valid <= 1'b1;
			end else if (out_ready) begin
				out_valid <= 1'b0;
			end
			if (push && !pop) begin
				cnt_q <= cnt_q + 1'b1;
			end else if (pop && !push) begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end

endmodule // pcm_word_fifo

// ---- core/pcm_serial_port.v ----
// Serial PCM highway port of the codec: prescaler, framing, shift logic.
`timescale 1ns/1ns
`include "pcm_regs.vh"

// Function
// - Auto-select divide ratio for 256 kHz tick
// - Prescaler independent of frame sync format
// - Eight-bit words, pin selects companding law
// - Mu-law zero and full-scale codes
// - A-law zero and full-scale codes
// - Eight-phase reference tone code sequence
// - Same serial timing for both laws
// - Frame syncs also time encode and decode
// - Two high falling edges mean long sync
// - Exactly one high falling edge: short sync
// - Transmit decision per frame, shared by receive
// - Long: drive once sync and clock high
// - Long: float after half-last-bit and sync low, whichever is later
// - Short: drive from next rise to mid-last-bit
// - Float two frames after reset or wake
// - Long: shift eight bits on falling edges
// - Long: hand word over on ninth rise
// - Short: sampled sync starts eight-bit capture
// - Short: hand word over on next rise
// - Receive works on its own sync and clock
// - Stuck receive clock selects common-clock mode
// - Power down on pin or idle syncs
// - Receive clocks may be asynchronous to transmit
// - Output floats unless a word is driven
module pcm_serial_port #(
	parameter PD_IDLE_CYC = `PCM_PD_IDLE_CYC
) (
	input  wire       clk_sys,
	input  wire       rst_b,
	input  wire       mclk_in,
	input  wire       tx_frame_sync,
	input  wire       tx_bit_clock,
	input  wire       rx_frame_sync,
	input  wire       rx_bit_clock,
	input  wire       rx_pcm_in,
	input  wire       powerdown_in_n,
	input  wire       law_select_a,
	output reg        tx_pcm_out,
	output reg        tx_pcm_oe,
	input  wire [1:0] tx_source_sel,
	input  wire [7:0] tx_word_in,
	output reg        encode_strobe,
	output reg        seq_tick,
	output reg  [4:0] prescale_ratio,
	output reg        long_frame_mode,
	output reg        powered_down,
	output reg        interchip_link_mode,
	output reg        general_circuit_mode,
	output wire       rx_word_valid,
	input  wire       rx_word_ready,
	output wire [7:0] rx_word_data,
	output reg        rx_overrun
);

	// ------------------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------------------
	// Chord and step of a fixed code for either law; sign is added outside.
	function [6:0] fixed_code;
		input       law_a;
		input [1:0] sel;
		begin
			if (sel == `PCM_SRC_FULL) begin
				fixed_code = law_a ? `PCM_A_FULL : `PCM_MU_FULL;
			end else begin
				fixed_code = law_a ? `PCM_A_ZERO : `PCM_MU_ZERO;
			end
		end
	endfunction

	// Reference tone: outer phases use one code, inner phases the other.
	function [7:0] tone_code;
		input       law_a;
		input [2:0] phase;
		reg         outer;
		begin
			outer = (phase[1:0] == 2'h0) || (phase[1:0] == 2'h3);
			if (outer) begin
				tone_code = {phase[2], law_a ? `PCM_A_TONE_A : `PCM_MU_TONE_A};
			end else begin
				tone_code = {phase[2], law_a ? `PCM_A_TONE_B : `PCM_MU_TONE_B};
			end
		end
	endfunction

	// Divide ratio from master-clock edges counted over one frame.
	function [4:0] ratio_of;
		input [9:0] edges;
		begin
			if (edges <= `PCM_EDGES_1X) begin
				ratio_of = `PCM_RATIO_1;
			end else if (edges <= `PCM_EDGES_2X) begin
				ratio_of = `PCM_RATIO_2;
			end else if (edges <= `PCM_EDGES_6X) begin
				ratio_of = `PCM_RATIO_6; // The 1.544 MHz clock also lands here.
			end else if (edges <= `PCM_EDGES_8X) begin
				ratio_of = `PCM_RATIO_8;
			end else if (edges <= `PCM_EDGES_10X) begin
				ratio_of = `PCM_RATIO_10;
			end else begin
				ratio_of = `PCM_RATIO_16;
			end
		end
	endfunction

	// ------------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------------
	wire [`PCM_PIN_COUNT-1:0] pin_raw;   // All asynchronous pins.
	reg  [`PCM_PIN_COUNT-1:0] pin_m_q;   // First stage, read only by the second.
	reg  [`PCM_PIN_COUNT-1:0] pin_s_q;   // Safe levels.
	reg  [`PCM_PIN_COUNT-1:0] pin_d_q;   // One cycle older, for edge detection.

	assign pin_raw = {law_select_a, powerdown_in_n, rx_pcm_in, rx_bit_clock,
		rx_frame_sync, tx_bit_clock, tx_frame_sync, mclk_in};

	genvar gi;
	generate
		for (gi = 0; gi < `PCM_PIN_COUNT; gi = gi + 1) begin : g_sync
			// Three flops per pin, two to synchronise and one for edges; receive pins are unrelated to transmit ones.
			always @(posedge clk_sys) begin
				// The power-down pin rests high, so its flops reset high; a low
				// reset value would fake a power-down right after reset ends.
				if (!rst_b) begin
					pin_m_q[gi] <= (gi == `PCM_PIN_PDN) ? 1'b1 : 1'b0;
					pin_s_q[gi] <= (gi == `PCM_PIN_PDN) ? 1'b1 : 1'b0;
					pin_d_q[gi] <= (gi == `PCM_PIN_PDN) ? 1'b1 : 1'b0;
				end else begin
					pin_m_q[gi] <= pin_raw[gi];
					pin_s_q[gi] <= pin_m_q[gi];
					pin_d_q[gi] <= pin_s_q[gi];
				end
			end
		end
	endgenerate

	wire tfs     = pin_s_q[`PCM_PIN_TFS];
	wire tbc     = pin_s_q[`PCM_PIN_TBC];
	wire rfs     = pin_s_q[`PCM_PIN_RFS];
	wire rbc     = pin_s_q[`PCM_PIN_RBC];
	wire law_a   = pin_s_q[`PCM_PIN_LAW];
	wire mclk_up = pin_s_q[`PCM_PIN_MCLK] & ~pin_d_q[`PCM_PIN_MCLK];
	wire tfs_up  = tfs & ~pin_d_q[`PCM_PIN_TFS];
	wire tbc_up  = tbc & ~pin_d_q[`PCM_PIN_TBC];
	wire tbc_dn  = ~tbc & pin_d_q[`PCM_PIN_TBC];
	wire rbc_up  = rbc & ~pin_d_q[`PCM_PIN_RBC];
	wire rbc_dn  = ~rbc & pin_d_q[`PCM_PIN_RBC];
	wire rbc_chg = rbc ^ pin_d_q[`PCM_PIN_RBC];

	// ------------------------------------------------------------------------
	// Prescaler
	// ------------------------------------------------------------------------
	reg [9:0] mclk_cnt_q;   // Master-clock edges since the last frame start.
	reg [4:0] div_cnt_q;    // Position inside the current divide period.

	// Only the frame-start edge is used, never its width, so the format
	// of the sync pulse cannot disturb the sequencing clock.
	always @(posedge clk_sys) begin
		if (!rst_b) begin
			mclk_cnt_q     <= 10'h000;
			div_cnt_q      <= 5'h00;
			prescale_ratio <= `PCM_RATIO_1;
			seq_tick       <= 1'b0;
		end else begin
			seq_tick <= 1'b0;
			if (tfs_up) begin
				prescale_ratio <= ratio_of(mclk_cnt_q);
				mclk_cnt_q     <= {9'h000, mclk_up};
			end else if (mclk_up && mclk_cnt_q != 10'h3FF) begin
				mclk_cnt_q <= mclk_cnt_q + 10'h001;
			end
			if (mclk_up) begin
				if (div_cnt_q + 5'h01 >= prescale_ratio) begin
					div_cnt_q <= 5'h00;
					seq_tick  <= 1'b1;
				end else begin
					div_cnt_q <= div_cnt_q + 5'h01;
				end
			end
		end
	end

	// ------------------------------------------------------------------------
	// Power-down, start-up guard and common-clock detection
	// ------------------------------------------------------------------------
	reg [31:0] idle_cnt_q;  // Cycles with both frame syncs low.
	reg [1:0]  arm_cnt_q;   // Frame starts seen since waking.
	reg [1:0]  stuck_cnt_q; // Frame starts with no receive clock change.
	reg        rbc_moved_q; // Receive clock changed since last frame start.
	wire       idle_pd   = (idle_cnt_q >= PD_IDLE_CYC);
	wire       pd_now    = !pin_s_q[`PCM_PIN_PDN] || idle_pd;
	wire       common    = interchip_link_mode || general_circuit_mode;
	wire       tx_armed  = (arm_cnt_q == `PCM_ARM_EDGES);

	always @(posedge clk_sys) begin
		if (!rst_b) begin
			idle_cnt_q           <= 32'h00000000;
			arm_cnt_q            <= 2'h0;
			stuck_cnt_q          <= 2'h0;
			rbc_moved_q          <= 1'b0;
			powered_down         <= 1'b0;
			interchip_link_mode  <= 1'b0;
			general_circuit_mode <= 1'b0;
		end else begin
			// Both syncs low for long enough, or the pin, powers down.
			if (tfs || rfs) begin
				idle_cnt_q <= 32'h00000000;
			end else if (!idle_pd) begin
				idle_cnt_q <= idle_cnt_q + 32'h00000001;
			end
			powered_down <= pd_now;
			// Driving stays barred until two full frames have passed.
			if (pd_now) begin
				arm_cnt_q <= 2'h0;
			end else if (tfs_up && !tx_armed) begin
				arm_cnt_q <= arm_cnt_q + 2'h1;
			end
			// A receive clock stuck across two frame starts means common clock.
			if (tfs_up) begin
				rbc_moved_q <= rbc_chg;
				if (rbc_moved_q || rbc_chg) begin
					stuck_cnt_q          <= 2'h0;
					interchip_link_mode  <= 1'b0;
					general_circuit_mode <= 1'b0;
				end else if (stuck_cnt_q == 2'h0) begin
					stuck_cnt_q <= 2'h1;
				end else begin
					interchip_link_mode  <= rbc;
					general_circuit_mode <= !rbc;
				end
			end else if (rbc_chg) begin
				rbc_moved_q <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------------------
	// Transmit framing and shifter
	// ------------------------------------------------------------------------
	reg [1:0] fs_hi_cnt_q; // Falling edges seen with the transmit sync high.
	reg       short_pend_q;// Short sync sampled, word starts on next rise.
	reg       tx_seen_q;   // A word already started inside this sync pulse.
	reg       tx_busy_q;   // Word in progress.
	reg       tx_long_q;   // Format of the word in progress.
	reg [3:0] tx_fall_q;   // Falling edges since the word started.
	reg [7:0] tx_sh_q;     // Remaining bits, next bit at the top.
	reg [2:0] tone_ph_q;   // Tone phase for the next word.
	reg [7:0] tx_word;     // Word chosen for the next transfer.
	wire      tx_run     = !powered_down && !common;
	wire      long_start = long_frame_mode && tfs && tbc && !tx_busy_q && !tx_seen_q;
	wire      short_start = short_pend_q && tbc_up && !tx_busy_q;
	wire      tx_bits_done = (tx_fall_q == `PCM_BITS);

	// The law only changes code values; framing below never reads it.
	always @* begin
		case (tx_source_sel)
			`PCM_SRC_USER: tx_word = tx_word_in;
			`PCM_SRC_ZERO: tx_word = {1'b1, fixed_code(law_a, tx_source_sel)};
			`PCM_SRC_TONE: tx_word = tone_code(law_a, tone_ph_q);
			default:       tx_word = {1'b1, fixed_code(law_a, tx_source_sel)};
		endcase
	end

	always @(posedge clk_sys) begin
		if (!rst_b) begin
			fs_hi_cnt_q     <= 2'h0;
			long_frame_mode <= 1'b0;
			short_pend_q    <= 1'b0;
			tx_seen_q       <= 1'b0;
			tx_busy_q       <= 1'b0;
			tx_long_q       <= 1'b0;
			tx_fall_q       <= 4'h0;
			tx_sh_q         <= 8'h00;
			tone_ph_q       <= 3'h0;
			tx_pcm_out      <= 1'b0;
			tx_pcm_oe       <= 1'b0;
			encode_strobe   <= 1'b0;
		end else begin
			encode_strobe <= 1'b0;
			if (!tfs) begin
				tx_seen_q <= 1'b0;
			end
			// Width of each sync pulse, in falling edges, picks the next format.
			if (tbc_dn) begin
				if (tfs) begin
					if (fs_hi_cnt_q != 2'h2) begin
						fs_hi_cnt_q <= fs_hi_cnt_q + 2'h1;
					end
					if (!long_frame_mode && !tx_busy_q) begin
						short_pend_q <= 1'b1;
					end
				end else if (fs_hi_cnt_q != 2'h0) begin
					long_frame_mode <= (fs_hi_cnt_q == 2'h2);
					fs_hi_cnt_q     <= 2'h0;
				end
			end
			if (!tx_run) begin
				// Power-down or a common-clock mode floats the output at once.
				tx_busy_q    <= 1'b0;
				tx_pcm_oe    <= 1'b0;
				short_pend_q <= 1'b0;
			end else if (long_start || short_start) begin
				// Word begins, sign bit first; the encoder is told too.
				tx_busy_q     <= 1'b1;
				tx_seen_q     <= 1'b1;
				short_pend_q  <= 1'b0;
				tx_long_q     <= long_start;
				tx_fall_q     <= 4'h0;
				tx_pcm_out    <= tx_word[7];
				tx_sh_q       <= {tx_word[6:0], 1'b0};
				tx_pcm_oe     <= tx_armed;
				tone_ph_q     <= tone_ph_q + 3'h1;
				encode_strobe <= 1'b1;
			end else if (tx_busy_q) begin
				if (tbc_up && !tx_bits_done) begin
					tx_pcm_out <= tx_sh_q[7];
					tx_sh_q    <= {tx_sh_q[6:0], 1'b0};
				end
				if (tbc_dn && !tx_bits_done) begin
					tx_fall_q <= tx_fall_q + 4'h1;
				end
				// Release at mid last bit, or when a long sync ends if later.
				if (tx_bits_done && (!tx_long_q || !tfs)) begin
					tx_busy_q <= 1'b0;
					tx_pcm_oe <= 1'b0;
				end
			end
		end
	end

	// ------------------------------------------------------------------------
	// Receive framing and shifter
	// ------------------------------------------------------------------------
	reg       rx_busy_q;   // Capture in progress.
	reg       rx_seen_q;   // A capture already started inside this sync pulse.
	reg [3:0] rx_cnt_q;    // Bits captured so far.
	reg [7:0] rx_sh_q;     // Assembling word, first bit ends at the top.
	reg       hold_v_q;    // Finished word waiting for FIFO space.
	reg [7:0] hold_q;      // That word.
	wire      fifo_ready;  // FIFO can take a word this cycle.
	// Format comes from the transmit decision, so one sync type serves both.
	wire      rx_long_start  = long_frame_mode && rfs && rbc && !rx_busy_q && !rx_seen_q;
	wire      rx_short_start = !long_frame_mode && rfs && rbc_dn && !rx_busy_q;
	wire      rx_handover    = rx_busy_q && (rx_cnt_q == `PCM_BITS) && rbc_up;

	always @(posedge clk_sys) begin
		if (!rst_b) begin
			rx_busy_q  <= 1'b0;
			rx_seen_q  <= 1'b0;
			rx_cnt_q   <= 4'h0;
			rx_sh_q    <= 8'h00;
			hold_v_q   <= 1'b0;
			hold_q     <= 8'h00;
			rx_overrun <= 1'b0;
		end else begin
			rx_overrun <= 1'b0;
			if (!rfs) begin
				rx_seen_q <= 1'b0;
			end
			if (!tx_run) begin
				rx_busy_q <= 1'b0;
			end else if (rx_long_start || rx_short_start) begin
				rx_busy_q <= 1'b1;
				rx_seen_q <= 1'b1;
				rx_cnt_q  <= 4'h0;
			end else if (rx_busy_q) begin
				if (rbc_dn && rx_cnt_q != `PCM_BITS) begin
					rx_sh_q  <= {rx_sh_q[6:0], pin_s_q[`PCM_PIN_RDAT]};
					rx_cnt_q <= rx_cnt_q + 4'h1;
				end
				if (rx_handover) begin
					rx_busy_q <= 1'b0;
				end
			end
			// The FIFO ready stalls delivery; a word arriving over an unsent one
			// replaces it, because the highway cannot be held back.
			if (rx_handover && tx_run) begin
				hold_q     <= rx_sh_q;
				hold_v_q   <= 1'b1;
				rx_overrun <= hold_v_q && !fifo_ready;
			end else if (hold_v_q && fifo_ready) begin
				hold_v_q <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------------
	// Received-word FIFO towards the decoder
	// ------------------------------------------------------------------------
	pcm_word_fifo #(
		.WIDTH (8),
		.DEPTH (`PCM_FIFO_DEPTH),
		.AW    (`PCM_FIFO_AW)
	) u_rx_fifo (
		.clk_sys   (clk_sys),
		.rst_b     (rst_b),
		.in_valid  (hold_v_q),
		.in_ready  (fifo_ready),
		.in_data   (hold_q),
		.out_valid (rx_word_valid),
		.out_ready (rx_word_ready),
		.out_data  (rx_word_data)
	);

endmodule // pcm_serial_port

// ---- sim/pcm_sp_checker.sv ----
// Concurrent checks on the ports of the PCM serial port.
`timescale 1ns/1ns
module pcm_sp_checker (
	input wire       clk_sys,
	input wire       rst_b,
	input wire       tx_pcm_out,
	input wire       tx_pcm_oe,
	input wire       encode_strobe,
	input wire       seq_tick,
	input wire [4:0] prescale_ratio,
	input wire       powered_down,
	input wire       interchip_link_mode,
	input wire       general_circuit_mode,
	input wire       rx_word_valid,
	input wire       rx_word_ready,
	input wire [7:0] rx_word_data,
	input wire       rx_overrun
);
	// ----
	// All checks share the system clock and its reset.
	// ----
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	a_pd_quiet: assert property (powered_down [*3] |-> !tx_pcm_oe)
		else $error("output driven while powered down");
	a_cc_quiet: assert property ((interchip_link_mode || general_circuit_mode) [*3] |-> !tx_pcm_oe)
		else $error("output driven in common clock mode");
	a_oe_word: assert property ($rose(tx_pcm_oe) |-> encode_strobe)
		else $error("word driven without encode start");
	a_oe_length: assert property ($rose(tx_pcm_oe) |-> tx_pcm_oe [*8])
		else $error("output enable too short");
	a_bit_hold: assert property (tx_pcm_oe && $changed(tx_pcm_out) |=>
		(!tx_pcm_oe || $stable(tx_pcm_out)) [*3])
		else $error("serial bit changed too soon");
	a_strobe_pulse: assert property (encode_strobe |=> !encode_strobe)
		else $error("encode strobe longer than one cycle");
	a_tick_pulse: assert property (seq_tick |=> !seq_tick)
		else $error("sequencing tick longer than one cycle");
	a_ratio_legal: assert property (prescale_ratio inside {5'h01, 5'h02, 5'h06, 5'h08, 5'h0A, 5'h10})
		else $error("illegal divide ratio");
	a_word_hold: assert property (rx_word_valid && !rx_word_ready |=>
		rx_word_valid && $stable(rx_word_data))
		else $error("received word dropped before accept");
	a_overrun_full: assert property (rx_overrun |-> rx_word_valid)
		else $error("overrun with empty buffer");
	c_word: cover property ($rose(tx_pcm_oe));
	c_overrun: cover property (rx_overrun);
	c_pd: cover property ($rose(powered_down));
endmodule // pcm_sp_checker

bind pcm_serial_port pcm_sp_checker pcm_sp_checker_inst (
	.clk_sys(clk_sys), .rst_b(rst_b), .tx_pcm_out(tx_pcm_out), .tx_pcm_oe(tx_pcm_oe),
	.encode_strobe(encode_strobe), .seq_tick(seq_tick), .prescale_ratio(prescale_ratio),
	.powered_down(powered_down), .interchip_link_mode(interchip_link_mode),
	.general_circuit_mode(general_circuit_mode), .rx_word_valid(rx_word_valid),
	.rx_word_ready(rx_word_ready), .rx_word_data(rx_word_data), .rx_overrun(rx_overrun)
);

// ---- sim/pcm_hwy_model.sv ----
// Behavioural highway switch: frame syncs, bit clocks and receive data.
`timescale 1ns/1ns
module pcm_hwy_model #(
	parameter NB   = 64,  // Bit clocks per frame.
	parameter HALF = 150  // Half bit period in ns, a whole number of system clocks.
) (
	output logic tx_frame_sync,
	output logic tx_bit_clock,
	output logic rx_frame_sync,
	output logic rx_bit_clock,
	output logic rx_pcm_in,
	input  wire  tx_pcm_out,
	input  wire  tx_pcm_oe
);
	// Clocks rest low between frames; frames follow closely so the receive clock never stalls.
	initial begin
		{tx_frame_sync, tx_bit_clock, rx_frame_sync, rx_bit_clock, rx_pcm_in} = 5'h00;
	end

	// One frame; bits 1..8 carry the word, sampled on falling edges.
	task automatic frame(input bit lng, input logic [7:0] w, output logic [7:0] got,
		output int nd);
		nd = 0;
		got = 8'h00;
		for (int b = 0; b < NB; b++) begin
			tx_bit_clock = 1'b1;
			rx_bit_clock = 1'b1;
			tx_frame_sync = lng ? (b >= 1 && b <= 3) : (b == 0);
			rx_frame_sync = tx_frame_sync;
			// Outside the word the line keeps moving so no stale bit passes for data.
			rx_pcm_in = (b >= 1 && b <= 8) ? w[8 - b] : ~rx_pcm_in;
			#HALF;
			tx_bit_clock = 1'b0;
			rx_bit_clock = 1'b0;
			if (tx_pcm_oe === 1'b1) begin
				nd++;
				if (b >= 1 && b <= 8) got[8 - b] = tx_pcm_out;
			end
			#HALF;
		end
	endtask
endmodule // pcm_hwy_model

// ---- sim/tb.sv ----
// Self-checking bench for the PCM serial port against the highway model.
`timescale 1ns/1ns
module tb;
	logic       clk_sys = 1'b0;
	logic       rst_b = 1'b0;
	logic       mclk_in = 1'b0;
	logic       law_select_a = 1'b0;
	logic       powerdown_in_n = 1'b1;
	logic       rx_word_ready = 1'b1;
	logic [1:0] tx_source_sel = 2'h0;
	logic [7:0] tx_word_in = 8'h00;
	logic [7:0] g, last_rx;
	wire        tx_frame_sync, tx_bit_clock, rx_frame_sync, rx_bit_clock, rx_pcm_in;
	wire        tx_pcm_out, tx_pcm_oe, rx_word_valid, rx_overrun, long_frame_mode, powered_down;
	wire [4:0]  prescale_ratio;
	wire [7:0]  rx_word_data;
	int         nd, mh = 4, n_rx = 0, n_ovr = 0, n_mismatch = 0, num_checks = 0;

	// ----
	// Clocks: master clock toggles every mh system cycles on the falling edge.
	// ----
	initial forever #5 clk_sys = ~clk_sys;
	initial forever begin
		repeat (mh) @(negedge clk_sys);
		mclk_in = ~mclk_in;
	end
	// Accepted words and overrun pulses are logged for later comparison.
	always @(posedge clk_sys) begin
		if (rx_word_valid === 1'b1 && rx_word_ready) begin
			last_rx <= rx_word_data;
			n_rx <= n_rx + 1;
		end
		if (rx_overrun === 1'b1) n_ovr <= n_ovr + 1;
	end

	pcm_serial_port pcm_serial_port_inst (
		.clk_sys(clk_sys), .rst_b(rst_b), .mclk_in(mclk_in), .tx_frame_sync(tx_frame_sync),
		.tx_bit_clock(tx_bit_clock), .rx_frame_sync(rx_frame_sync), .rx_bit_clock(rx_bit_clock),
		.rx_pcm_in(rx_pcm_in), .powerdown_in_n(powerdown_in_n), .law_select_a(law_select_a),
		.tx_pcm_out(tx_pcm_out), .tx_pcm_oe(tx_pcm_oe), .tx_source_sel(tx_source_sel),
		.tx_word_in(tx_word_in), .encode_strobe(), .seq_tick(), .prescale_ratio(prescale_ratio),
		.long_frame_mode(long_frame_mode), .powered_down(powered_down), .interchip_link_mode(),
		.general_circuit_mode(), .rx_word_valid(rx_word_valid), .rx_word_ready(rx_word_ready),
		.rx_word_data(rx_word_data), .rx_overrun(rx_overrun)
	);
	pcm_hwy_model pcm_hwy_model_inst (
		.tx_frame_sync(tx_frame_sync), .tx_bit_clock(tx_bit_clock), .rx_frame_sync(rx_frame_sync),
		.rx_bit_clock(rx_bit_clock), .rx_pcm_in(rx_pcm_in), .tx_pcm_out(tx_pcm_out),
		.tx_pcm_oe(tx_pcm_oe)
	);

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %0t seen %h want %h", $time, seen, exp);
		end
	endtask

	// One frame; drv 0 wants silence, 1 the word w both ways, 3 a driven word, 2 no judgement.
	task automatic frm(input bit lng, input logic [7:0] w, input int drv);
		tx_word_in = w;
		pcm_hwy_model_inst.frame(lng, w, g, nd);
		if (drv == 0) chk(8'(nd), 8'h00);
		if (drv == 1 || drv == 3) chk(8'(nd), 8'h08);
		if (drv == 1) chk(g, w);
		if (drv == 1) chk(last_rx, w);
	endtask

	task automatic t_arm();
		frm(0, 8'h11, 0);
		frm(0, 8'h22, 0);
		frm(0, 8'hA5, 1);
		$display("end arm");
	endtask

	// A format change takes effect one pulse after the pulse that shows it.
	task automatic t_long();
		frm(1, 8'h3C, 2);
		chk(8'(long_frame_mode), 8'h01);
		frm(1, 8'hC3, 1);
		frm(0, 8'h5A, 2);
		chk(8'(long_frame_mode), 8'h00);
		frm(0, 8'h96, 1);
		$display("end long");
	endtask

	// Every master clock rate once, each with one of zero, tone or full-scale; each of those sources under both laws.
	task automatic t_codes();
		int rt[6] = '{1, 2, 6, 8, 10, 16};
		int ht[6] = '{30, 12, 6, 4, 3, 2};
		for (int i = 0; i < 6; i++) begin
			mh = ht[i];
			law_select_a = (i >= 3);
			tx_source_sel = 2'(i % 3 + 1);
			repeat (2) begin
				frm(0, 8'(i), 3);
				if (i % 3 == 0) chk(g, law_select_a ? 8'hD5 : 8'hFF);
				if (i % 3 == 2) chk(g, law_select_a ? 8'hAA : 8'h80);
				if (i % 3 == 1) chk(8'(g[6:0] == (law_select_a ? 7'h34 : 7'h1E) ||
					g[6:0] == (law_select_a ? 7'h21 : 7'h0B)), 8'h01);
			end
			chk(8'(prescale_ratio), 8'(rt[i]));
		end
		tx_source_sel = 2'h0;
		law_select_a = 1'b0;
		mh = 4;
		$display("end codes");
	endtask

	// Consumer stalls until the buffer overflows once, then drains it.
	task automatic t_fifo();
		int r0;
		rx_word_ready = 1'b0;
		for (int i = 0; i < 19; i++) frm(0, 8'(8'h40 + i), 2);
		chk(8'(n_ovr), 8'h01);
		r0 = n_rx;
		rx_word_ready = 1'b1;
		repeat (40) @(negedge clk_sys);
		chk(8'(n_rx - r0), 8'h12);
		chk(last_rx, 8'h52);
		$display("end fifo");
	endtask

	task automatic t_pd();
		powerdown_in_n = 1'b0;
		repeat (10) @(negedge clk_sys);
		chk(8'(powered_down), 8'h01);
		frm(0, 8'h77, 0);
		powerdown_in_n = 1'b1;
		t_arm();
		$display("end powerdown");
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	initial begin
		repeat (10) @(negedge clk_sys);
		rst_b = 1'b1;
		chk(8'(tx_pcm_oe), 8'h00);
		t_arm();
		t_long();
		t_codes();
		t_fifo();
		t_pd();
		finish_test();
	end
	// A hang counts as a mismatch.
	initial begin
		#950000;
		n_mismatch++;
		finish_test();
	end
endmodule // tb
